// ---- sirs_pkg.sv ----
/*
 the package holds the constants shared by the shell exception-input block
 and its synchroniser bank; it assumes a single 125 MHz system clock
*/
package sirs_pkg;
    localparam int          EXT_IRQ_W     = 6;
    localparam int          VEC_W         = 30;
    localparam int          PC_W          = 32;
    localparam int          SYNC_W        = 10;
    localparam int          CLK_MHZ       = 125;
    localparam logic [31:0] NMI_VECTOR    = 32'hbfc0_0000;
    localparam logic [31:0] PC_RESET      = 32'hbfc0_0000;
    localparam logic [1:0]  VEC_LOW_BITS  = 2'h0;
    localparam logic [5:0]  IRQ_IDLE_N    = 6'h3f;
    localparam logic [5:0]  MASK_ZERO     = 6'h00;
    // positions of each input in the synchroniser bank
    localparam int          SB_IRQ_LO     = 0;
    localparam int          SB_IRQ_HI     = 5;
    localparam int          SB_NMI        = 6;
    localparam int          SB_WARM       = 7;
    localparam int          SB_COLD       = 8;
    localparam int          SB_VEC        = 9;
    // every bank input is active low, so all of them idle high
    localparam logic [9:0]  SYNC_IDLE     = 10'h3ff;

    typedef enum logic [1:0] {
        VS_IDLE,
        VS_ACK,
        VS_WAIT_REL
    } sirs_vec_state_t;

    typedef enum logic [1:0] {
        RS_NONE,
        RS_WARM,
        RS_COLD
    } sirs_rst_kind_t;
endpackage : sirs_pkg

// ---- sirs_sync_if.sv ----
/*
 the interface carries the raw and synchronised exception inputs between the
 main block and the synchroniser bank; both run on the same clock
*/
`timescale 1ns/1ps
interface sirs_sync_if;
    logic [sirs_pkg::SYNC_W-1:0] raw;
    logic [sirs_pkg::SYNC_W-1:0] synced;
    modport src  (output raw, input synced);
    modport bank (input raw, output synced);
endinterface : sirs_sync_if

// ---- sirs_sync.sv ----
/*
 the file holds a two-flop synchroniser bank; it assumes asynchronous inputs
 and a reset value equal to each input's idle level
*/
`timescale 1ns/1ps
module sirs_sync (
    input  wire logic  clk,  // system clock
    input  wire logic  rst,  // async reset, active high
    sirs_sync_if.bank  sif   // raw in, synced out
);
    typedef struct packed {
        logic [sirs_pkg::SYNC_W-1:0] meta;
        logic [sirs_pkg::SYNC_W-1:0] sync;
    } sirs_sync_st_t;

    sirs_sync_st_t st_r;
    sirs_sync_st_t st_nxt;

    ////////////////////////////////////////////////////////////////////
    // first stage feeds only the second stage
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.meta = sif.raw;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r.meta <= sirs_pkg::SYNC_IDLE;
            st_r.sync <= sirs_pkg::SYNC_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign sif.synced = st_r.sync;
endmodule : sirs_sync

// ---- sirs_shell_exc.sv ----
/*
 the file holds the shell's exception and reset input logic: vectored irq
 handshake, six external irq lines, nmi, warm and cold reset, strap bits;
 assumes the controller holds the vector stable and irq lines until serviced
*/
`timescale 1ns/1ps
// What this block does
// - vectored irq input raises an external interrupt exception
// - capture vector bits 31:2 on strobe, load straight into pc
// - drive vector ack output once the vector has been taken
// - any of six low irq lines raises exception and sets pending bit
// - no irq line taken unless global enable set; per-line masks; vectored irq not gated
// - pending bits follow inputs even while masked
// - all six irq inputs pass through clocked synchronisers
// - nmi synchronised, takes exception vectored to 0xbfc00000
// - warm reset synchronised, held while asserted unless cold reset is also asserted, exits on release
// - cold reset synchronised, held while asserted, exits on release
// - force-uncached strap low makes every cache access miss
// - endian strap low selects big-endian byte positions
// - system data bus byte order is little endian
module sirs_shell_exc (
    input  wire logic                               clk,                // system clock
    input  wire logic                               rst,                // async reset
    input  wire logic                               vectored_irq_n,     // vectored irq, low
    input  wire logic [sirs_pkg::VEC_W-1:0]         vector_addr,        // vector bits 31:2
    input  wire logic                               vector_addr_strobe_n, // vector valid, low
    input  wire logic [sirs_pkg::EXT_IRQ_W-1:0]     ext_irq_n,          // external irqs, low
    input  wire logic                               nmi_in_n,           // nmi, low
    input  wire logic                               warm_rst_n,         // warm reset, low
    input  wire logic                               cold_rst_n,         // cold reset, low
    input  wire logic                               force_uncached_n,   // strap, low forces miss
    input  wire logic                               big_endian_sel_n,   // strap, low big endian
    input  wire logic                               irq_global_en,      // status irq enable
    input  wire logic [sirs_pkg::EXT_IRQ_W-1:0]     irq_mask,           // per-line enables
    input  wire logic                               exc_taken,          // core entered handler
    output logic                                    vector_addr_ack_n,  // vector ack, low
    output logic [sirs_pkg::PC_W-1:0]               pc_load_addr,       // pc load value
    output logic                                    pc_load,            // pc load pulse
    output logic                                    ext_exc_req,        // external irq exception
    output logic                                    nmi_exc_req,        // nmi exception pulse
    output logic [sirs_pkg::EXT_IRQ_W-1:0]          pending_field,      // cause pending bits
    output logic                                    warm_rst_active,    // in warm reset
    output logic                                    cold_rst_active,    // in cold reset
    output logic                                    cache_force_miss,   // all accesses uncached
    output logic                                    big_endian_mode,    // big endian selected
    output logic                                    sys_data_bus_le     // data bus little endian
);
    typedef struct packed {
        sirs_pkg::sirs_vec_state_t     vstate;
        logic                          ack_n;
        logic [sirs_pkg::PC_W-1:0]     pc_addr;
        logic                          pc_load;
        logic                          vec_req;
        logic                          ext_req;
        logic                          nmi_prev;
        logic                          nmi_req;
        logic [sirs_pkg::EXT_IRQ_W-1:0] pend;
        sirs_pkg::sirs_rst_kind_t      rkind;
        logic                          warm_act;
        logic                          cold_act;
        logic                          miss;
        logic                          big;
        logic                          le_bus;
    } sirs_state_t;

    sirs_state_t st_r;
    sirs_state_t st_nxt;

    sirs_sync_if sif ();

    logic [sirs_pkg::EXT_IRQ_W-1:0] irq_s;
    logic                           nmi_s;
    logic                           warm_s;
    logic                           cold_s;
    logic                           vstb_s;

    ////////////////////////////////////////////////////////////////////
    // the vector strobe is synchronised with the irq lines, nmi and resets (vectored irq is not);
    // the vector bus itself is held stable so it is sampled directly
    // irq line synchronisers
    assign sif.raw = {vector_addr_strobe_n, cold_rst_n, warm_rst_n, nmi_in_n, ext_irq_n};

    sirs_sync u_sync (
        .clk (clk),
        .rst (rst),
        .sif (sif)
    );

    assign irq_s  = ~sif.synced[sirs_pkg::SB_IRQ_HI:sirs_pkg::SB_IRQ_LO];
    assign nmi_s  = ~sif.synced[sirs_pkg::SB_NMI];
    assign warm_s = ~sif.synced[sirs_pkg::SB_WARM];
    assign cold_s = ~sif.synced[sirs_pkg::SB_COLD];
    assign vstb_s = ~sif.synced[sirs_pkg::SB_VEC];

    // builds a full pc from the 30-bit word vector
    function automatic logic [sirs_pkg::PC_W-1:0] vec_to_pc(
        input logic [sirs_pkg::VEC_W-1:0] v
    );
        vec_to_pc = {v, sirs_pkg::VEC_LOW_BITS};
    endfunction : vec_to_pc

    // nmi acts on its synchronised assertion edge only, not on the level
    function automatic logic nmi_edge(
        input logic now_s,
        input logic prev_s
    );
        nmi_edge = now_s & ~prev_s;
    endfunction : nmi_edge

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.pc_load = 1'b0;
        st_nxt.nmi_req = 1'b0;

        // pending follows lines regardless of mask
        st_nxt.pend = irq_s;

        // irq lines gated by global and line enables; the vectored request is not gated
        st_nxt.ext_req = st_r.vec_req
                       | (irq_global_en & (|(irq_s & irq_mask)));

        // nmi edge gives one exception, vectored to boot address
        st_nxt.nmi_prev = nmi_s;
        if (nmi_edge(nmi_s, st_r.nmi_prev))
        begin
            st_nxt.nmi_req = 1'b1;
            st_nxt.pc_addr = sirs_pkg::NMI_VECTOR;
            st_nxt.pc_load = 1'b1;
        end

        // vectored request held until the core takes it
        if (!vectored_irq_n)
        begin
            st_nxt.vec_req = 1'b1;
        end
        else if (exc_taken)
        begin
            st_nxt.vec_req = 1'b0;
        end

        case (st_r.vstate)
            sirs_pkg::VS_IDLE:
            begin
                // vector stable while strobe is up, so sample here
                if (vstb_s && !nmi_edge(nmi_s, st_r.nmi_prev))
                begin
                    st_nxt.pc_addr = vec_to_pc(vector_addr);
                    st_nxt.pc_load = 1'b1;
                    st_nxt.vstate  = sirs_pkg::VS_ACK;
                    st_nxt.ack_n   = 1'b0;
                end
            end
            sirs_pkg::VS_ACK:
            begin
                st_nxt.vstate = sirs_pkg::VS_WAIT_REL;
            end
            sirs_pkg::VS_WAIT_REL:
            begin
                // ack held until the strobe drops, so no vector is taken twice
                if (!vstb_s)
                begin
                    st_nxt.ack_n  = 1'b1;
                    st_nxt.vstate = sirs_pkg::VS_IDLE;
                end
            end
            default:
            begin
                st_nxt.vstate = sirs_pkg::VS_IDLE;
                st_nxt.ack_n  = 1'b1;
            end
        endcase

        if (cold_s)
        begin
            st_nxt.rkind = sirs_pkg::RS_COLD;
        end
        else if (warm_s)
        begin
            st_nxt.rkind = sirs_pkg::RS_WARM;
        end
        else
        begin
            st_nxt.rkind = sirs_pkg::RS_NONE;
        end
        // each reset output gets its own flop, so no decode glitches reach pins
        st_nxt.warm_act = (st_nxt.rkind == sirs_pkg::RS_WARM);
        st_nxt.cold_act = (st_nxt.rkind == sirs_pkg::RS_COLD);

        // straps are static, sampled every cycle after reset release
        // low strap forces miss
        st_nxt.miss   = ~force_uncached_n;
        st_nxt.big    = ~big_endian_sel_n;
        // system data bus always little endian
        st_nxt.le_bus = 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r.vstate   <= sirs_pkg::VS_IDLE;
            st_r.ack_n    <= 1'b1;
            st_r.pc_addr  <= sirs_pkg::PC_RESET;
            st_r.pc_load  <= 1'b0;
            st_r.vec_req  <= 1'b0;
            st_r.ext_req  <= 1'b0;
            st_r.nmi_prev <= 1'b0;
            st_r.nmi_req  <= 1'b0;
            st_r.pend     <= sirs_pkg::MASK_ZERO;
            st_r.rkind    <= sirs_pkg::RS_NONE;
            st_r.warm_act <= 1'b0;
            st_r.cold_act <= 1'b0;
            st_r.miss     <= 1'b0;
            st_r.big      <= 1'b0;
            st_r.le_bus   <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign vector_addr_ack_n = st_r.ack_n;
    assign pc_load_addr      = st_r.pc_addr;
    assign pc_load           = st_r.pc_load;
    assign ext_exc_req       = st_r.ext_req;
    assign nmi_exc_req       = st_r.nmi_req;
    assign pending_field     = st_r.pend;
    assign warm_rst_active   = st_r.warm_act;
    assign cold_rst_active   = st_r.cold_act;
    assign cache_force_miss  = st_r.miss;
    assign big_endian_mode   = st_r.big;
    assign sys_data_bus_le   = st_r.le_bus;
endmodule : sirs_shell_exc

// ---- sirs_checker.sv ----
/* assertions on the shell exception-input ports
   assumes one clock domain and the async active-high reset */
`timescale 1ns/1ps
module sirs_checker (
    input wire logic        clk,               // clock
    input wire logic        rst,               // reset
    input wire logic        vectored_irq_n,    // in
    input wire logic [29:0] vector_addr,       // in
    input wire logic [5:0]  ext_irq_n,         // in
    input wire logic        nmi_in_n,          // in
    input wire logic        warm_rst_n,        // in
    input wire logic        cold_rst_n,        // in
    input wire logic        force_uncached_n,  // in
    input wire logic        big_endian_sel_n,  // in
    input wire logic        irq_global_en,     // in
    input wire logic [5:0]  irq_mask,          // in
    input wire logic        vector_addr_ack_n, // out
    input wire logic [31:0] pc_load_addr,      // out
    input wire logic        pc_load,           // out
    input wire logic        ext_exc_req,       // out
    input wire logic        nmi_exc_req,       // out
    input wire logic [5:0]  pending_field,     // out
    input wire logic        warm_rst_active,   // out
    input wire logic        cold_rst_active,   // out
    input wire logic        cache_force_miss,  // out
    input wire logic        big_endian_mode    // out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_ack_load; $fell(vector_addr_ack_n) |-> pc_load && !nmi_exc_req; endproperty
    a_ack_load: assert property (p_ack_load) else $error("ack without pc load");
    property p_vec_pc; pc_load && !nmi_exc_req |-> pc_load_addr == {vector_addr, 2'h0}; endproperty
    a_vec_pc: assert property (p_vec_pc) else $error("vector load value wrong");
    property p_nmi;
        $fell(nmi_in_n) |-> ##3 nmi_exc_req && pc_load && pc_load_addr == 32'hbfc0_0000
            ##1 !nmi_exc_req;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi exception wrong");
    property p_pend; pending_field == ~$past(ext_irq_n, 3); endproperty
    a_pend: assert property (p_pend) else $error("pending bits wrong");
    property p_mask;
        $rose(ext_exc_req) && $past(vectored_irq_n, 2) && $past(vectored_irq_n)
            |-> $past(irq_global_en) && |(pending_field & $past(irq_mask));
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq taken");
    property p_vec_irq; $fell(vectored_irq_n) |-> ##2 ext_exc_req; endproperty
    a_vec_irq: assert property (p_vec_irq) else $error("vectored irq not raised");
    property p_cold; cold_rst_active == !$past(cold_rst_n, 3); endproperty
    a_cold: assert property (p_cold) else $error("cold reset state wrong");
    property p_warm; warm_rst_active == (!$past(warm_rst_n, 3) && $past(cold_rst_n, 3)); endproperty
    a_warm: assert property (p_warm) else $error("warm reset state wrong");
    property p_strap;
        cache_force_miss == !$past(force_uncached_n) && big_endian_mode == !$past(big_endian_sel_n);
    endproperty
    a_strap: assert property (p_strap) else $error("strap output wrong");
    c_nmi: cover property (nmi_exc_req);
    c_vec: cover property (pc_load && !nmi_exc_req);
    c_masked: cover property (|pending_field && !ext_exc_req);
endmodule : sirs_checker
bind sirs_shell_exc sirs_checker u_chk (.clk, .rst, .vectored_irq_n, .vector_addr, .ext_irq_n,
    .nmi_in_n, .warm_rst_n, .cold_rst_n, .force_uncached_n, .big_endian_sel_n, .irq_global_en,
    .irq_mask, .vector_addr_ack_n, .pc_load_addr, .pc_load, .ext_exc_req, .nmi_exc_req,
    .pending_field, .warm_rst_active, .cold_rst_active, .cache_force_miss, .big_endian_mode);

// ---- sirs_ctrl_model.sv ----
/* bus-converter side of the vector handshake
   assumes the shell answers on the rising clock edge */
`timescale 1ns/1ps
module sirs_ctrl_model (
    input  wire logic                         clk,      // clock
    input  wire logic                         ack_n,    // vector ack
    output logic                              strobe_n, // vector valid
    output logic [sirs_pkg::VEC_W-1:0]        addr      // vector bits
);
    initial
    begin
        strobe_n = 1'b1;
        addr     = '0;
    end
    task automatic send_vec(input logic [sirs_pkg::VEC_W-1:0] a, input int slow,
                            output logic acked);
        int n;
        @(negedge clk);
        addr     = a;
        strobe_n = 1'b0;
        n        = 0;
        while (ack_n !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        acked    = (ack_n === 1'b0);
        repeat (slow) @(posedge clk);
        @(negedge clk);
        strobe_n = 1'b1;
        // released bus must not keep a stale value
        addr     = ~a;
        while (ack_n !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
    endtask : send_vec
endmodule : sirs_ctrl_model

// ---- tb_sirs_shell_exc.sv ----
/* self-checking bench for the shell exception inputs
   assumes the checker is bound to the design top */
`timescale 1ns/1ps
module tb_sirs_shell_exc;
    typedef struct packed {logic [5:0] irq_n; logic [5:0] mask; logic gen;
                           logic [5:0] pend; logic req;} sirs_row_t;
    logic clk = 1'b0, rst = 1'b1, vec_n = 1'b1, nmi_n = 1'b1, warm_n = 1'b1, cold_n = 1'b1;
    logic miss_n = 1'b1, big_n = 1'b1, gen = 1'b0, taken = 1'b0, strobe_n, ack_n, pc_load;
    logic ext_req, nmi_req, warm_act, cold_act, miss, big, le, acked;
    logic [5:0] irq_n = 6'h3f, mask = 6'h00, pend;
    logic [29:0] vaddr;
    logic [31:0] pc_addr;
    int errors = 0, tests_run = 0;
    sirs_row_t rows [5] = '{'{6'h3e, 6'h01, 1'h1, 6'h01, 1'h1}, '{6'h3e, 6'h00, 1'h1, 6'h01, 1'h0},
                            '{6'h1f, 6'h20, 1'h0, 6'h20, 1'h0}, '{6'h00, 6'h3f, 1'h1, 6'h3f, 1'h1},
                            '{6'h3f, 6'h3f, 1'h1, 6'h00, 1'h0}};
    always #4 clk = ~clk;
    sirs_ctrl_model u_ctrl (.clk(clk), .ack_n(ack_n), .strobe_n(strobe_n), .addr(vaddr));
    sirs_shell_exc dut (.clk(clk), .rst(rst), .vectored_irq_n(vec_n), .vector_addr(vaddr),
        .vector_addr_strobe_n(strobe_n), .ext_irq_n(irq_n), .nmi_in_n(nmi_n), .warm_rst_n(warm_n),
        .cold_rst_n(cold_n), .force_uncached_n(miss_n), .big_endian_sel_n(big_n),
        .irq_global_en(gen), .irq_mask(mask), .exc_taken(taken), .vector_addr_ack_n(ack_n),
        .pc_load_addr(pc_addr), .pc_load(pc_load), .ext_exc_req(ext_req), .nmi_exc_req(nmi_req),
        .pending_field(pend), .warm_rst_active(warm_act), .cold_rst_active(cold_act),
        .cache_force_miss(miss), .big_endian_mode(big), .sys_data_bus_le(le));
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word
    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_word(name, {31'h0, exp}, {31'h0, got});
    endtask : chk_bit
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        errors++;
        finish_test();
    end
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk_word("pc_load_addr", sirs_pkg::PC_RESET, pc_addr);
        chk_bit("sys_data_bus_le", 1'h1, le);
        foreach (rows[i])
        begin
            {irq_n, mask, gen} = {rows[i].irq_n, rows[i].mask, rows[i].gen};
            repeat (4) @(negedge clk);
            chk_word("pending_field", {26'h0, rows[i].pend}, {26'h0, pend});
            chk_bit("ext_exc_req", rows[i].req, ext_req);
        end
        vec_n = 1'b0;
        repeat (3) @(negedge clk);
        chk_bit("ext_exc_req", 1'h1, ext_req);
        {vec_n, taken} = 2'h3;
        @(negedge clk);
        taken = 1'b0;
        repeat (2) @(negedge clk);
        chk_bit("ext_exc_req", 1'h0, ext_req);
        u_ctrl.send_vec(30'h2aaa_5555, 0, acked);
        chk_bit("vector_addr_ack_n low", 1'h1, acked);
        @(negedge clk);
        chk_word("pc_load_addr", {30'h2aaa_5555, 2'h0}, pc_addr);
        u_ctrl.send_vec(30'h0f0f_0f0f, 3, acked);
        chk_bit("vector_addr_ack_n low", 1'h1, acked);
        @(negedge clk);
        chk_word("pc_load_addr", {30'h0f0f_0f0f, 2'h0}, pc_addr);
        chk_bit("vector_addr_ack_n", 1'h1, ack_n);
        nmi_n = 1'b0;
        repeat (3) @(negedge clk);
        chk_bit("nmi_exc_req", 1'h1, nmi_req);
        chk_bit("pc_load", 1'h1, pc_load);
        @(negedge clk);
        chk_word("pc_load_addr", 32'hbfc0_0000, pc_addr);
        chk_bit("nmi_exc_req", 1'h0, nmi_req);
        nmi_n = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            {cold_n, warm_n} = i[1:0];
            repeat (4) @(negedge clk);
            chk_bit("cold_rst_active", !cold_n, cold_act);
            chk_bit("warm_rst_active", !warm_n && cold_n, warm_act);
        end
        {miss_n, big_n} = 2'h0;
        repeat (2) @(negedge clk);
        chk_bit("cache_force_miss", 1'h1, miss);
        chk_bit("big_endian_mode", 1'h1, big);
        finish_test();
    end
endmodule : tb_sirs_shell_exc
